// ---- bench/amp_serial_sva.sv ----
/* port checker for amp_serial.
   assumes one clock, bound to every amp_serial. */
`timescale 1ns/1ns
module amp_serial_sva (
   input wire MCLK_I,
   input wire RST_I,
   input wire TXD_O,
   input wire TX_ENABLE_I,
   input wire RX_INTR_EN_I,
   input wire TX_INTR_EN_I,
   input wire TX_END_INTR_EN_I,
   input wire ERR_ONLY_INTR_I,
   input wire [7:0] RX_DATA_O,
   input wire RX_FULL_O,
   input wire OVERRUN_O,
   input wire FRAMING_O,
   input wire PARITY_O,
   input wire TX_EMPTY_O,
   input wire TX_END_O,
   input wire RX_FULL_IRQ_O,
   input wire RX_ERR_IRQ_O,
   input wire TX_EMPTY_IRQ_O,
   input wire TX_END_IRQ_O,
   input wire DMA_RX_REQ_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   a_dma_on_rise: assert property (
      DMA_RX_REQ_O == $rose(RX_FULL_O)) else $error("dma request wrong");
   a_rx_full_irq: assert property (
      (RX_FULL_O && RX_INTR_EN_I && !ERR_ONLY_INTR_I)[*2] |-> RX_FULL_IRQ_O)
      else $error("rx full irq missing");
   a_rx_err_irq: assert property (
      ((OVERRUN_O || FRAMING_O || PARITY_O) && RX_INTR_EN_I)[*2]
      |-> RX_ERR_IRQ_O) else $error("rx error irq missing");
   a_tx_empty_irq: assert property (
      !$past(RST_I) |-> TX_EMPTY_IRQ_O == ($past(TX_EMPTY_O)
      && $past(TX_INTR_EN_I))) else $error("tx empty irq wrong");
   a_tx_end_irq: assert property (
      !$past(RST_I) |-> TX_END_IRQ_O == ($past(TX_END_O)
      && $past(TX_END_INTR_EN_I))) else $error("tx end irq wrong");
   a_overrun_keeps_data: assert property (
      $rose(OVERRUN_O) |-> $stable(RX_DATA_O) && !$rose(RX_FULL_O))
      else $error("overrun changed data");
   a_error_blocks_rx: assert property (
      $past(OVERRUN_O) || $past(FRAMING_O) || $past(PARITY_O)
      |-> !$rose(RX_FULL_O)) else $error("rx full set after error");
   a_bad_frame_no_full: assert property (
      $rose(FRAMING_O) || $rose(PARITY_O) |-> !$rose(RX_FULL_O))
      else $error("rx full set on bad frame");
   a_tx_off_state: assert property (
      !TX_ENABLE_I [*2] |-> TX_EMPTY_O && TX_END_O && TXD_O)
      else $error("transmitter not reset");
   a_mark_line: assert property (
      TX_END_O [*2] |-> TXD_O) else $error("line low after end");
endmodule // amp_serial_sva
bind amp_serial amp_serial_sva chk (.*);

// ---- bench/amp_serial_tb.sv ----
/* self-checking bench for amp_serial.
   assumes amp_station on the line and the bound checker. */
`timescale 1ns/1ns
module amp_serial_tb;
   localparam BIT_CYC = 32;
   reg clk, rst, tx_en, rx_en, char7, par_en, par_odd, mp_fmt, two_stop;
   reg rx_ie, tx_ie, tx_end_flag_ie, err_only, mp_send, mp_set, wvalid, low_seen;
   reg [3:0] clr;
   reg [7:0] wdata;
   wire rxd, txd, wready, full, ovr, frm, par, mp_bit_received, mp_intr_enable, temp, tx_end_flag, dma;
   wire [7:0] rdata;
   wire [3:0] irq;
   integer miscompares, tests_run;
   amp_station #(.BIT_CYC(BIT_CYC)) st (.clk_i(clk), .txd_i(txd),
      .line_o(rxd));
   amp_serial #(.OVS_DIV(2)) dut (.MCLK_I(clk), .RST_I(rst), .RXD_I(rxd),
      .TXD_O(txd), .TX_ENABLE_I(tx_en), .RX_ENABLE_I(rx_en),
      .CHAR7_I(char7), .PARITY_EN_I(par_en), .PARITY_ODD_I(par_odd),
      .MP_FORMAT_I(mp_fmt), .TWO_STOP_I(two_stop), .RX_INTR_EN_I(rx_ie),
      .TX_INTR_EN_I(tx_ie), .TX_END_INTR_EN_I(tx_end_flag_ie),
      .ERR_ONLY_INTR_I(err_only), .MP_BIT_SEND_I(mp_send),
      .MP_INTR_EN_SET_I(mp_set), .RX_FULL_CLR_I(clr[0]),
      .OVERRUN_CLR_I(clr[1]), .FRAMING_CLR_I(clr[2]),
      .PARITY_CLR_I(clr[3]), .TX_WDATA_I(wdata), .TX_WVALID_I(wvalid),
      .TX_WREADY_O(wready), .RX_DATA_O(rdata), .RX_FULL_O(full),
      .OVERRUN_O(ovr), .FRAMING_O(frm), .PARITY_O(par), .MP_BIT_RX_O(mp_bit_received),
      .MP_INTR_EN_O(mp_intr_enable), .TX_EMPTY_O(temp), .TX_END_O(tx_end_flag),
      .RX_FULL_IRQ_O(irq[0]), .RX_ERR_IRQ_O(irq[1]),
      .TX_EMPTY_IRQ_O(irq[2]), .TX_END_IRQ_O(irq[3]), .DMA_RX_REQ_O(dma));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task chk(input string nm, input [7:0] e, input [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   // clear strobes: 0 full, 1 overrun, 2 framing, 3 parity
   task pulse(input [3:0] m);
      @(posedge clk);
      clr <= m;
      @(posedge clk);
      clr <= 4'h0;
   endtask
   task wr(input [7:0] d);
      int n;
      wdata <= d;
      wvalid <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         if (wready !== 1'b1) low_seen = 1'b1;
         n++;
      end while (wready !== 1'b1 && n < 6000);
      @(posedge clk);
   endtask
   task t_rx_good;
      @(posedge clk);
      par_en <= 1'b1;
      rx_ie <= 1'b1;
      st.send(8'hA7, 8, 1, ^8'hA7, 1);
      chk("rx data", 8'hA7, rdata);
      chk("rx full", 8'h01, full);
      chk("rx errors", 8'h00, {ovr, frm, par});
      chk("rx irq", 8'h01, irq[0]);
      @(posedge clk);
      err_only <= 1'b1;
      repeat (3) @(negedge clk);
      chk("rx irq err only", 8'h00, irq[0]);
      pulse(4'h1);
      err_only <= 1'b0;
      $display("test rx_good done");
   endtask
   task t_overrun;
      st.send(8'h3C, 8, 1, ^8'h3C, 1);
      st.send(8'hC3, 8, 1, ^8'hC3, 1);
      chk("overrun", 8'h01, ovr);
      chk("overrun data", 8'h3C, rdata);
      chk("err irq", 8'h01, irq[1]);
      pulse(4'h1);
      st.send(8'h55, 8, 1, ^8'h55, 1);
      chk("blocked full", 8'h00, full);
      chk("blocked data", 8'h3C, rdata);
      pulse(4'h2);
      st.send(8'h55, 8, 1, ^8'h55, 1);
      chk("resumed data", 8'h55, rdata);
      pulse(4'h1);
      $display("test overrun done");
   endtask
   task t_errors;
      par_odd <= 1'b1;
      st.send(8'h0F, 8, 1, ^8'h0F, 1);
      chk("parity flag", 8'h01, par);
      chk("parity data", 8'h0F, rdata);
      chk("parity full", 8'h00, full);
      pulse(4'h8);
      st.send(8'hF0, 8, 1, ~^8'hF0, 0);
      chk("framing flags", 8'h02, {frm, par});
      chk("framing data", 8'hF0, rdata);
      pulse(4'h4);
      par_odd <= 1'b0;
      $display("test errors done");
   endtask
   task t_mp_rx;
      mp_fmt <= 1'b1;
      char7 <= 1'b1;
      mp_set <= 1'b1;
      @(posedge clk);
      mp_set <= 1'b0;
      st.send(8'h13, 7, 1, 0, 1);
      chk("foreign full", 8'h01, full);
      chk("parity ignored", 8'h00, par);
      chk("mp enable kept", 8'h01, mp_intr_enable);
      chk("mp bit zero", 8'h00, mp_bit_received);
      pulse(4'h1);
      st.send(8'hC5, 7, 1, 1, 1);
      chk("mp enable cleared", 8'h00, mp_intr_enable);
      chk("mp bit one", 8'h01, mp_bit_received);
      chk("seven bit data", 8'h45, rdata);
      pulse(4'h1);
      $display("test mp_rx done");
   endtask
   task t_tx;
      logic [7:0] d;
      bit xb, sp;
      chk("tx end idle", 8'h01, tx_end_flag);
      char7 <= 1'b0;
      two_stop <= 1'b1;
      mp_send <= 1'b1;
      tx_ie <= 1'b1;
      tx_end_flag_ie <= 1'b1;
      low_seen = 1'b0;
      fork
         begin
            @(posedge clk);
            for (int k = 0; k < 5; k++) wr(8'h81 + 8'h29 * k);
            wvalid <= 1'b0;
         end
         for (int k = 0; k < 5; k++) begin
            st.listen(d, xb, sp);
            chk("tx data", 8'h81 + 8'h29 * k, d);
            chk("tx mp and stop", 8'h03, {xb, sp});
         end
      join
      chk("ready refused", 8'h01, low_seen);
      repeat (2 * BIT_CYC) @(negedge clk);
      chk("tx end", 8'h01, tx_end_flag);
      chk("tx irqs", 8'h0C, irq & 4'hC);
      $display("test tx done");
   endtask
   task t_off;
      @(posedge clk);
      wr(8'h00);
      wvalid <= 1'b0;
      repeat (3 * BIT_CYC) @(posedge clk);
      tx_en <= 1'b0;
      repeat (3) @(negedge clk);
      chk("tx off", 8'h07, {temp, tx_end_flag, txd});
      @(posedge clk);
      tx_en <= 1'b1;
      rx_en <= 1'b0;
      st.send(8'h99, 8, 1, 1, 1);
      chk("rx off data", 8'h45, rdata);
      chk("rx off full", 8'h00, full);
      rx_en <= 1'b1;
      par_en <= 1'b0;
      mp_fmt <= 1'b0;
      st.send(8'h6B, 8, 0, 0, 1);
      chk("plain frame data", 8'h6B, rdata);
      chk("plain frame full", 8'h01, full);
      $display("test off done");
   endtask
   task report_and_stop;
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      miscompares = 0;
      tests_run = 0;
      {rst, tx_en, rx_en} = 3'h7;
      {char7, par_en, par_odd, mp_fmt, two_stop, rx_ie} = 6'h00;
      {tx_ie, tx_end_flag_ie, err_only, mp_send, mp_set, wvalid} = 6'h00;
      clr = 4'h0;
      wdata = 8'h00;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      chk("reset state", 8'h07, {full, temp, tx_end_flag, txd});
      t_rx_good;
      t_overrun;
      t_errors;
      t_mp_rx;
      t_tx;
      t_off;
      report_and_stop;
   end
   initial begin
      // generous over the roughly 6300 cycles the tests take
      repeat (60000) @(posedge clk);
      miscompares++;
      report_and_stop;
   end
endmodule // amp_serial_tb

// ---- bench/amp_station.sv ----
/* remote station on the shared serial line.
   assumes a bit lasts BIT_CYC clocks. */
`timescale 1ns/1ns
module amp_station #(
   parameter BIT_CYC = 32
) (
   input wire clk_i,
   input wire txd_i,
   output reg line_o
);
   initial line_o = 1'b1;
   task automatic put(input bit b);
      line_o <= b;
      repeat (BIT_CYC) @(posedge clk_i);
   endtask
   // xb goes in the extra slot only when xen
   task automatic send(input [7:0] d, input int nb, input bit xen,
      input bit xb, input bit stp);
      @(posedge clk_i);
      put(1'b0);
      for (int i = 0; i < nb; i++) put(d[i]);
      if (xen) put(xb);
      put(stp);
      put(1'b1);
   endtask
   // samples mid-bit; extra slot and two stop bits assumed
   task automatic listen(output [7:0] d, output bit xb, output bit sp);
      int n;
      n = 0;
      d = 8'h00;
      while (txd_i !== 1'b0 && n < 6000) begin
         @(negedge clk_i);
         n++;
      end
      repeat (BIT_CYC / 2) @(negedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(negedge clk_i);
         d[i] = txd_i;
      end
      repeat (BIT_CYC) @(negedge clk_i);
      xb = txd_i;
      repeat (BIT_CYC) @(negedge clk_i);
      sp = txd_i;
      repeat (BIT_CYC) @(negedge clk_i);
      sp = sp & txd_i;
   endtask
endmodule // amp_station

// ---- rtl/amp_regs.vh ----
/*
 * Constants of the asynchronous multiprocessor serial unit:
 * timing counts, bit-sampling point and reset values.
 * Assumes a 50 MHz system clock.
 */
`ifndef AMP_REGS_VH
`define AMP_REGS_VH
`define AMP_CLK_HZ 50000000
`define AMP_BAUD 115200
`define AMP_OVS 16
`define AMP_OVS_DIV (`AMP_CLK_HZ / (`AMP_BAUD * `AMP_OVS))
`define AMP_SAMPLE_PT 4'h7
`define AMP_LAST_SUB 4'hF
`define AMP_LAST_BIT8 3'h7
`define AMP_LAST_BIT7 3'h6
`define AMP_RST_TX_EMPTY 1'b1
`define AMP_RST_TX_END 1'b1
`define AMP_RST_FLAG 1'b0
`define AMP_RST_DATA 8'h00
`endif

// ---- rtl/amp_serial.v ----
/*
 * Asynchronous serial unit with multiprocessor function: receiver
 * with parity/stop/overrun checks, transmitter, two-entry transmit
 * buffer. Assumes control bits and clear strobes come from logic on
 * MCLK_I; RXD_I is an unsynchronised pin.
 */
// Operation
// R1: falling start bit syncs timing, starts capture
// R2: data shifted in LSB first
// R3: parity checked against odd/even select
// R4: first stop bit must be high
// R5: good frame loads data, sets rx full
// R6: completion while full sets overrun, keeps data
// R7: framing/parity errors flagged, data still loaded
// R8: parity error follows mode odd/even setting
// R9: errors block reception until software clears
// R10: rx full irq when enabled, not error-only
// R11: error irq on any error when enabled
// R12: every rx full rise requests dma
// R13: multiprocessor format ignores parity enable
// R14: sender sends ID mp=1 then data mp=0
// R15: mp frame: start, data, mp bit, stops
// R16: tx empty clear loads shifter, sets empty
// R17: empty at stop time sets tx end
// R18: mp bit one clears mp interrupt enable
// R19: overrun test at stop position
// R20: foreign data still sets rx full
// R21: software tracks ID/data state itself
// R22: ID send needs tx end, mp bit set
// R23: each write needs tx empty read first
// R24: 16x oversampling, sample on eighth pulse
// R25: tx disable resets shifter, rx keeps flags
// R26: four setting bits pick twelve formats
// R27: high line idle until falling edge
`timescale 1ns/1ns
`include "amp_regs.vh"
module amp_serial #(
   parameter OVS_DIV = `AMP_OVS_DIV,
   parameter DIV_W = 16
) (
   input wire MCLK_I,
   input wire RST_I,
   input wire RXD_I,
   output reg TXD_O,
   input wire TX_ENABLE_I,
   input wire RX_ENABLE_I,
   input wire CHAR7_I,
   input wire PARITY_EN_I,
   input wire PARITY_ODD_I,
   input wire MP_FORMAT_I,
   input wire TWO_STOP_I,
   input wire RX_INTR_EN_I,
   input wire TX_INTR_EN_I,
   input wire TX_END_INTR_EN_I,
   input wire ERR_ONLY_INTR_I,
   input wire MP_BIT_SEND_I,
   input wire MP_INTR_EN_SET_I,
   input wire RX_FULL_CLR_I,
   input wire OVERRUN_CLR_I,
   input wire FRAMING_CLR_I,
   input wire PARITY_CLR_I,
   input wire [7:0] TX_WDATA_I,
   input wire TX_WVALID_I,
   output reg TX_WREADY_O,
   output reg [7:0] RX_DATA_O,
   output reg RX_FULL_O,
   output reg OVERRUN_O,
   output reg FRAMING_O,
   output reg PARITY_O,
   output reg MP_BIT_RX_O,
   output reg MP_INTR_EN_O,
   output reg TX_EMPTY_O,
   output reg TX_END_O,
   output reg RX_FULL_IRQ_O,
   output reg RX_ERR_IRQ_O,
   output reg TX_EMPTY_IRQ_O,
   output reg TX_END_IRQ_O,
   output reg DMA_RX_REQ_O
);
   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_START = 5'b00010;
   localparam [4:0] S_DATA = 5'b00100;
   localparam [4:0] S_XBIT = 5'b01000;
   localparam [4:0] S_STOP = 5'b10000;
   localparam integer DIV_LAST_I = OVS_DIV - 1;
   localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_I[DIV_W-1:0];

   reg rxd_s1, rxd_s2, rxd_prev;
   reg [DIV_W-1:0] div_cnt;
   reg tick;
   reg [4:0] rx_st, tx_st;
   reg [3:0] rx_sub, tx_sub;
   reg [2:0] rx_bit, tx_bit;
   reg [7:0] rx_shift_reg, tx_shift_reg, tx_data_reg;
   reg rx_xbit, rx_stop, rx_done, tx_xbit;
   reg [7:0] buf_mem [0:1];
   reg buf_wp, buf_rp;
   reg [1:0] buf_cnt, next_cnt;
   reg next_full, next_overrun_flag, next_fer, next_per;

   wire err_any = OVERRUN_O | FRAMING_O | PARITY_O;
   wire [2:0] last_bit = CHAR7_I ? `AMP_LAST_BIT7 : `AMP_LAST_BIT8;
   wire with_xbit = PARITY_EN_I | MP_FORMAT_I;
   wire rx_samp = tick & (rx_sub == `AMP_SAMPLE_PT);
   wire [7:0] rx_word = CHAR7_I ? {1'b0, rx_shift_reg[7:1]} :
      rx_shift_reg;
   wire par_bad = PARITY_EN_I & ~MP_FORMAT_I &
      ((^rx_word ^ rx_xbit) != PARITY_ODD_I); // R13
   wire set_overrun_flag = rx_done & RX_FULL_O;
   wire set_fer = rx_done & ~rx_stop;
   wire set_per = rx_done & par_bad;
   wire rx_load = rx_done & ~RX_FULL_O;
   wire set_full = rx_load & ~rx_stop ? 1'b0 : rx_load & ~par_bad;
   wire tx_bit_end = tick & (tx_sub == `AMP_LAST_SUB);
   wire buf_valid = (buf_cnt != 2'd0);
   wire buf_push = TX_WVALID_I & TX_WREADY_O;
   wire drain = buf_valid & TX_EMPTY_O & TX_ENABLE_I; // R23
   wire load_now = TX_ENABLE_I & ~TX_EMPTY_O &
      ((tx_st == S_IDLE) | ((tx_st == S_STOP) & tx_bit_end &
      (tx_bit == 3'd0)));
   wire [7:0] tx_word = CHAR7_I ? {1'b0, tx_data_reg[6:0]} :
      tx_data_reg;

   // pin synchroniser; the second stage and its delayed copy rxd_prev are looked at
   always @(posedge MCLK_I) begin
      if (RST_I) begin
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
         rxd_prev <= 1'b1;
      end else begin
         rxd_s1 <= RXD_I;
         rxd_s2 <= rxd_s1;
         rxd_prev <= rxd_s2;
      end
   end

   // shared 16x oversampling tick
   always @(posedge MCLK_I) begin
      if (RST_I) begin
         div_cnt <= {DIV_W{1'b0}};
         tick <= 1'b0;
      end else begin
         tick <= (div_cnt == DIV_LAST); // R24
         if (div_cnt == DIV_LAST)
            div_cnt <= {DIV_W{1'b0}};
         else
            div_cnt <= div_cnt + 1'b1;
      end
   end

   always @(posedge MCLK_I) begin
      if (RST_I) begin
         rx_st <= S_IDLE;
         rx_sub <= 4'h0;
         rx_bit <= 3'h0;
         rx_shift_reg <= `AMP_RST_DATA;
         rx_xbit <= 1'b0;
         rx_stop <= 1'b1;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (!RX_ENABLE_I) begin
            rx_st <= S_IDLE; // R25
         end else begin
            if (tick)
               rx_sub <= rx_sub + 4'h1;
            case (rx_st)
               S_IDLE: begin
                  // an idle high line is ignored until it falls
                  if (rxd_prev & ~rxd_s2 & ~err_any) begin // R27 R1 R9
                     rx_st <= S_START;
                     rx_sub <= 4'h0;
                  end
               end
               S_START: begin
                  if (rx_samp) begin
                     rx_bit <= 3'h0;
                     rx_st <= rxd_s2 ? S_IDLE : S_DATA; // R1
                  end
               end
               S_DATA: begin
                  if (rx_samp) begin
                     rx_shift_reg <= {rxd_s2, rx_shift_reg[7:1]}; // R2
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == last_bit)
                        rx_st <= with_xbit ? S_XBIT : S_STOP; // R26
                  end
               end
               S_XBIT: begin
                  if (rx_samp) begin
                     rx_xbit <= rxd_s2;
                     rx_st <= S_STOP;
                  end
               end
               S_STOP: begin
                  // second stop bit is never examined
                  if (rx_samp) begin
                     rx_stop <= rxd_s2; // R4
                     rx_done <= 1'b1;
                     rx_st <= S_IDLE;
                  end
               end
               default: rx_st <= S_IDLE;
            endcase
         end
      end
   end

   // status flags: a set in the same cycle as a clear wins
   always @* begin
      next_full = (RX_FULL_O & ~RX_FULL_CLR_I) | set_full; // R5 R20
      next_overrun_flag = (OVERRUN_O & ~OVERRUN_CLR_I) | set_overrun_flag; // R6 R19
      next_fer = (FRAMING_O & ~FRAMING_CLR_I) | set_fer; // R7
      next_per = (PARITY_O & ~PARITY_CLR_I) | set_per; // R3 R8
   end

   always @(posedge MCLK_I) begin
      if (RST_I) begin
         RX_FULL_O <= `AMP_RST_FLAG;
         OVERRUN_O <= `AMP_RST_FLAG;
         FRAMING_O <= `AMP_RST_FLAG;
         PARITY_O <= `AMP_RST_FLAG;
         RX_DATA_O <= `AMP_RST_DATA;
         MP_BIT_RX_O <= `AMP_RST_FLAG;
         MP_INTR_EN_O <= `AMP_RST_FLAG;
         RX_FULL_IRQ_O <= 1'b0;
         RX_ERR_IRQ_O <= 1'b0;
         DMA_RX_REQ_O <= 1'b0;
      end else begin
         RX_FULL_O <= next_full;
         OVERRUN_O <= next_overrun_flag;
         FRAMING_O <= next_fer;
         PARITY_O <= next_per;
         if (rx_load)
            RX_DATA_O <= rx_word; // R7
         if (rx_done & MP_FORMAT_I)
            MP_BIT_RX_O <= rx_xbit;
         // hardware clear beats a simultaneous software set
         if (rx_done & MP_FORMAT_I & rx_xbit)
            MP_INTR_EN_O <= 1'b0; // R18
         else if (MP_INTR_EN_SET_I)
            MP_INTR_EN_O <= 1'b1;
         RX_FULL_IRQ_O <= next_full & RX_INTR_EN_I &
            ~ERR_ONLY_INTR_I; // R10
         RX_ERR_IRQ_O <= (next_overrun_flag | next_fer | next_per) &
            RX_INTR_EN_I; // R11
         DMA_RX_REQ_O <= set_full; // R12
      end
   end

   // two-entry transmit buffer; ready drops when both slots hold data
   always @* begin
      next_cnt = buf_cnt;
      if (buf_push & ~drain)
         next_cnt = buf_cnt + 2'd1;
      else if (drain & ~buf_push)
         next_cnt = buf_cnt - 2'd1;
   end

   always @(posedge MCLK_I) begin
      if (RST_I) begin
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         buf_cnt <= 2'd0;
         TX_WREADY_O <= 1'b0;
      end else begin
         buf_cnt <= next_cnt;
         TX_WREADY_O <= (next_cnt != 2'd2);
         if (buf_push)
            buf_wp <= ~buf_wp;
         if (drain)
            buf_rp <= ~buf_rp;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_slot
         always @(posedge MCLK_I) begin
            if (RST_I)
               buf_mem[gi] <= `AMP_RST_DATA;
            else if (buf_push & (buf_wp == gi))
               buf_mem[gi] <= TX_WDATA_I;
         end
      end
   endgenerate

   always @(posedge MCLK_I) begin
      if (RST_I) begin
         tx_st <= S_IDLE;
         tx_sub <= 4'h0;
         tx_bit <= 3'h0;
         tx_shift_reg <= `AMP_RST_DATA;
         tx_data_reg <= `AMP_RST_DATA;
         tx_xbit <= 1'b1;
         TX_EMPTY_O <= `AMP_RST_TX_EMPTY;
         TX_END_O <= `AMP_RST_TX_END;
         TXD_O <= 1'b1;
      end else if (!TX_ENABLE_I) begin
         tx_st <= S_IDLE; // R25
         tx_shift_reg <= `AMP_RST_DATA;
         TX_EMPTY_O <= 1'b1;
         TX_END_O <= 1'b1;
         TXD_O <= 1'b1;
      end else begin
         if (tick)
            tx_sub <= tx_sub + 4'h1;
         if (drain) begin
            tx_data_reg <= buf_mem[buf_rp];
            TX_EMPTY_O <= 1'b0;
         end
         if (load_now) begin
            tx_shift_reg <= tx_word; // R16
            tx_xbit <= MP_FORMAT_I ? MP_BIT_SEND_I :
               (^tx_word ^ PARITY_ODD_I); // R15 R13
            TX_EMPTY_O <= 1'b1; // R16
            TX_END_O <= 1'b0;
            tx_st <= S_START;
            tx_sub <= 4'h0;
         end else begin
            case (tx_st)
               S_IDLE: tx_sub <= 4'h0;
               S_START: begin
                  if (tx_bit_end) begin
                     tx_bit <= 3'h0;
                     tx_st <= S_DATA;
                  end
               end
               S_DATA: begin
                  if (tx_bit_end) begin
                     tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                     tx_bit <= tx_bit + 3'h1;
                     if (tx_bit == last_bit)
                        tx_st <= with_xbit ? S_XBIT : S_STOP;
                     if (tx_bit == last_bit)
                        tx_bit <= TWO_STOP_I ? 3'h1 : 3'h0;
                     if (tx_bit == last_bit & ~with_xbit)
                        TX_END_O <= TX_EMPTY_O; // R17
                  end
               end
               S_XBIT: begin
                  if (tx_bit_end) begin
                     tx_st <= S_STOP;
                     TX_END_O <= TX_EMPTY_O; // R17
                  end
               end
               S_STOP: begin
                  // stays in mark state afterwards; idle sends 1
                  if (tx_bit_end) begin
                     if (tx_bit != 3'h0)
                        tx_bit <= tx_bit - 3'h1;
                     else
                        tx_st <= S_IDLE;
                  end
               end
               default: tx_st <= S_IDLE;
            endcase
         end
         case (tx_st)
            S_START: TXD_O <= 1'b0;
            S_DATA: TXD_O <= tx_shift_reg[0]; // R15
            S_XBIT: TXD_O <= tx_xbit;
            default: TXD_O <= 1'b1;
         endcase
      end
   end

   always @(posedge MCLK_I) begin
      if (RST_I) begin
         TX_EMPTY_IRQ_O <= 1'b0;
         TX_END_IRQ_O <= 1'b0;
      end else begin
         TX_EMPTY_IRQ_O <= TX_EMPTY_O & TX_INTR_EN_I; // R16
         TX_END_IRQ_O <= TX_END_O & TX_END_INTR_EN_I; // R17
      end
   end
endmodule // amp_serial
